// File: rtl/uic_pkg.sv
// uic_pkg: offsets, field positions, reset values and identity bytes for the
// interrupt clear and identification register bank.
// assumes a plain strobe register port, 32-bit data, byte addresses.
package uic_pkg;
  // instance bases on the peripheral bus
  localparam logic [31:0] UIC_BASE_0 = 32'h4000_C000;
  localparam logic [31:0] UIC_BASE_1 = 32'h4000_D000;
  // size of one instance window
  localparam logic [31:0] UIC_WIN_MASK = 32'hFFFF_F000;
  localparam int UIC_OFS_W = 12;
  // register offsets within an instance
  localparam logic [11:0] UIC_OFS_RAW = 12'h03C;
  localparam logic [11:0] UIC_OFS_MASK = 12'h038;
  localparam logic [11:0] UIC_OFS_MIS = 12'h040;
  localparam logic [11:0] UIC_OFS_CLEAR = 12'h044;
  localparam logic [11:0] UIC_OFS_ID4 = 12'hFD0;
  localparam logic [11:0] UIC_OFS_ID5 = 12'hFD4;
  localparam logic [11:0] UIC_OFS_ID6 = 12'hFD8;
  localparam logic [11:0] UIC_OFS_ID7 = 12'hFDC;
  localparam logic [11:0] UIC_OFS_ID0 = 12'hFE0;
  localparam logic [11:0] UIC_OFS_ID1 = 12'hFE4;
  localparam logic [11:0] UIC_OFS_ID2 = 12'hFE8;
  // clear and status field positions
  localparam int UIC_BIT_RX = 4;
  localparam int UIC_BIT_TX = 5;
  localparam int UIC_BIT_RT = 6;
  localparam int UIC_BIT_FE = 7;
  localparam int UIC_EV_LO = 4;
  localparam int UIC_EV_HI = 7;
  localparam int UIC_NEV = 4;
  localparam logic [3:0] UIC_EV_RESET = 4'h0;
  localparam logic [31:0] UIC_ZERO = 32'h0000_0000;
  localparam logic [11:0] UIC_OFS_ZERO = 12'h000;
  // identity bytes: values are arbitrary
  localparam logic [7:0] UIC_ID_BYTE0 = 8'h5A;
  localparam logic [7:0] UIC_ID_BYTE1 = 8'h01;
  localparam logic [7:0] UIC_ID_BYTE2 = 8'h2C;
  localparam logic [7:0] UIC_ID_BYTE4 = 8'h3C;
  localparam logic [7:0] UIC_ID_BYTE5 = 8'h47;
  localparam logic [7:0] UIC_ID_BYTE6 = 8'h62;
  localparam logic [7:0] UIC_ID_BYTE7 = 8'h7E;
endpackage

// File: rtl/uic_sticky.sv
// uic_sticky: one sticky event flag with write-one clear.
// assumes event and clear are one-cycle pulses on the single clock.
`timescale 1ns/1ps
`default_nettype none
module uic_sticky (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag
);
  // set beats clear so a coincident event is never lost
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else if (event_in) begin
      flag <= 1'b1;
    end else if (clear_in) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/uic_ident.sv
// uic_ident: read-only identification byte lookup by offset.
// assumes offsets are byte addresses within one instance window.
`timescale 1ns/1ps
`default_nettype none
module uic_ident (
  input wire logic [11:0] offset,
  output logic hit,
  output logic [7:0] ident_byte
);
  // constants only: no storage, so writes can never alter them
  always_comb begin
    hit = 1'b1;
    unique case (offset)
      uic_pkg::UIC_OFS_ID4: ident_byte = uic_pkg::UIC_ID_BYTE4;
      uic_pkg::UIC_OFS_ID5: ident_byte = uic_pkg::UIC_ID_BYTE5;
      uic_pkg::UIC_OFS_ID6: ident_byte = uic_pkg::UIC_ID_BYTE6;
      uic_pkg::UIC_OFS_ID7: ident_byte = uic_pkg::UIC_ID_BYTE7;
      uic_pkg::UIC_OFS_ID0: ident_byte = uic_pkg::UIC_ID_BYTE0;
      uic_pkg::UIC_OFS_ID1: ident_byte = uic_pkg::UIC_ID_BYTE1;
      uic_pkg::UIC_OFS_ID2: ident_byte = uic_pkg::UIC_ID_BYTE2;
      default: begin
        hit = 1'b0;
        ident_byte = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/uic_regs.sv
// uic_regs: two instances of the interrupt clear and identification bank.
// assumes a single-cycle strobe register port; read data one cycle later.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uic_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [31:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  input wire logic [3:0] events_0,
  input wire logic [3:0] events_1,
  output logic irq_0,
  output logic irq_1
);
  // instance select from the upper address bits
  logic sel_0;
  logic sel_1;
  logic [11:0] offset;
  logic is_clear;
  // decode both windows, offsets relative to each base
  always_comb begin
    sel_0 = (address & uic_pkg::UIC_WIN_MASK) == uic_pkg::UIC_BASE_0;
    sel_1 = (address & uic_pkg::UIC_WIN_MASK) == uic_pkg::UIC_BASE_1;
    offset = address[uic_pkg::UIC_OFS_W-1:0];
    is_clear = write_strobe && (offset == uic_pkg::UIC_OFS_CLEAR);
  end

  // per instance state
  logic [3:0] clear_0;
  logic [3:0] clear_1;
  logic [3:0] raw_0;
  logic [3:0] raw_1;
  logic [3:0] mask_0;
  logic [3:0] mask_1;
  // only ones in the event field clear; zeros and reserved bits do nothing
  always_comb begin
    clear_0 = (is_clear && sel_0) ?
      write_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO] : uic_pkg::UIC_EV_RESET;
    clear_1 = (is_clear && sel_1) ?
      write_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO] : uic_pkg::UIC_EV_RESET;
  end

  // one sticky flag per event per instance
  genvar gi;
  generate
    for (gi = 0; gi < uic_pkg::UIC_NEV; gi++) begin : g_ev
      uic_sticky u_s0 (
        .clock(clock),
        .arst_n(arst_n),
        .event_in(events_0[gi]),
        .clear_in(clear_0[gi]),
        .flag(raw_0[gi])
      );
      uic_sticky u_s1 (
        .clock(clock),
        .arst_n(arst_n),
        .event_in(events_1[gi]),
        .clear_in(clear_1[gi]),
        .flag(raw_1[gi])
      );
    end
  endgenerate

  // enable mask registers, writable by software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_0 <= uic_pkg::UIC_EV_RESET;
      mask_1 <= uic_pkg::UIC_EV_RESET;
    end else if (write_strobe && offset == uic_pkg::UIC_OFS_MASK) begin
      if (sel_0) begin
        mask_0 <= write_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO];
      end
      if (sel_1) begin
        mask_1 <= write_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO];
      end
    end
  end

  // masked status follows raw, so a clear drops both at once
  logic [3:0] mis_0;
  logic [3:0] mis_1;
  always_comb begin
    mis_0 = raw_0 & mask_0;
    mis_1 = raw_1 & mask_1;
    irq_0 = |mis_0;
    irq_1 = |mis_1;
  end

  // identification lookup, shared by both instances since contents match
  logic id_hit;
  logic [7:0] id_byte;
  uic_ident u_ident (
    .offset(offset),
    .hit(id_hit),
    .ident_byte(id_byte)
  );

  // read mux for the selected instance
  logic [31:0] next_read_data;
  logic [3:0] rd_raw;
  logic [3:0] rd_mask;
  logic [3:0] rd_mis;
  always_comb begin
    next_read_data = uic_pkg::UIC_ZERO;
    rd_raw = sel_1 ? raw_1 : raw_0;
    rd_mask = sel_1 ? mask_1 : mask_0;
    rd_mis = sel_1 ? mis_1 : mis_0;
    if (read_strobe && (sel_0 || sel_1)) begin
      if (id_hit) begin
        next_read_data = {24'h000000, id_byte};
      end else if (offset == uic_pkg::UIC_OFS_RAW) begin
        next_read_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO] = rd_raw;
      end else if (offset == uic_pkg::UIC_OFS_MASK) begin
        next_read_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO] = rd_mask;
      end else if (offset == uic_pkg::UIC_OFS_MIS) begin
        next_read_data[uic_pkg::UIC_EV_HI:uic_pkg::UIC_EV_LO] = rd_mis;
      end
      // clear register and unmapped offsets read zero
    end
  end

  // read data registered; stands one cycle, zero otherwise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      read_data <= uic_pkg::UIC_ZERO;
    end else begin
      read_data <= next_read_data;
    end
  end

  // checks
  clear_drops_raw_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_FE] && !events_0[3]) |=> !raw_0[3])
    else $error("framing clear did not clear flag");
  rt_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_RT] && !events_0[2]) |=> !raw_0[2])
    else $error("timeout clear did not clear flag");
  tx_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_TX] && !events_1[1]) |=> !raw_1[1])
    else $error("transmit clear did not clear flag");
  rx_zero_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_0[0] && !(is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_RX])) |=> raw_0[0])
    else $error("receive flag lost without a clear");
  id_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_0 && offset == uic_pkg::UIC_OFS_ID0)
      |=> read_data == {24'h000000, uic_pkg::UIC_ID_BYTE0})
    else $error("identification byte wrong");
  id_upper_a: assert property (@(posedge clock) disable iff (!arst_n)
    $past(read_strobe) && $past(id_hit) |-> read_data[31:8] == 24'h000000)
    else $error("identification upper bits not zero");
  inst_split_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && raw_0[0] && !events_0[0]) |=> raw_0[0])
    else $error("clear leaked into other instance");
  masked_drop_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && (write_data[7:4] == 4'hF) && events_0 == 4'h0) |=> !irq_0)
    else $error("interrupt stayed after full clear");
  set_wins_a: assert property (@(posedge clock) disable iff (!arst_n)
    (events_0[3] && is_clear && sel_0) |=> raw_0[3])
    else $error("coincident event lost");

  // second window: framing clear must reach its own flag
  fe_clear_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_FE] && !events_1[3])
    |=> !raw_1[3])
    else $error("framing clear did not clear second flag");

  // second window: timeout clear
  rt_clear_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_RT] && !events_1[2])
    |=> !raw_1[2])
    else $error("timeout clear did not clear second flag");

  // first window: transmit clear, the path software uses most
  tx_clear_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_TX] && !events_0[1])
    |=> !raw_0[1])
    else $error("transmit clear did not clear flag");

  // first window: receive clear
  rx_clear_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_RX] && !events_0[0])
    |=> !raw_0[0])
    else $error("receive clear did not clear flag");

  // second window: receive clear
  rx_clear_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_RX] && !events_1[0])
    |=> !raw_1[0])
    else $error("receive clear did not clear second flag");

  // a zero on the framing bit must leave the flag alone
  fe_zero_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_0[3] && !(is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_FE]))
    |=> raw_0[3])
    else $error("framing flag lost without a clear");

  // a zero on the timeout bit must leave the flag alone
  rt_zero_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_0[2] && !(is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_RT]))
    |=> raw_0[2])
    else $error("timeout flag lost without a clear");

  // a zero on the transmit bit must leave the flag alone
  tx_zero_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_0[1] && !(is_clear && sel_0 && write_data[uic_pkg::UIC_BIT_TX]))
    |=> raw_0[1])
    else $error("transmit flag lost without a clear");

  // second window: receive flag holds without its clear
  rx_keeps_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_1[0] && !(is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_RX]))
    |=> raw_1[0])
    else $error("second receive flag lost without a clear");

  // second window: framing flag holds without its clear
  fe_keeps_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (raw_1[3] && !(is_clear && sel_1 && write_data[uic_pkg::UIC_BIT_FE]))
    |=> raw_1[3])
    else $error("second framing flag lost without a clear");

  // every event pulse leaves its flag set, clear or not
  event_sets_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    (events_0 != uic_pkg::UIC_EV_RESET)
    |=> ((raw_0 & $past(events_0)) == $past(events_0)))
    else $error("event did not set its flag");

  // same for the second window
  event_sets_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (events_1 != uic_pkg::UIC_EV_RESET)
    |=> ((raw_1 & $past(events_1)) == $past(events_1)))
    else $error("second event did not set its flag");

  // second window: event beats a coincident clear
  set_wins_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (events_1[3] && is_clear && sel_1)
    |=> raw_1[3])
    else $error("second coincident event lost");

  // the receive flag rises only on an event, never by itself
  no_spurious_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!raw_0[0] && !events_0[0])
    |=> !raw_0[0])
    else $error("receive flag set without event");

  // a clear in the first window must not touch the second
  inst_split_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_0 && raw_1[3] && !events_1[3])
    |=> raw_1[3])
    else $error("clear leaked into second instance");

  // enables move only on a write to their own window
  mask_keep_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(write_strobe && sel_0 && offset == uic_pkg::UIC_OFS_MASK)
    |=> $stable(mask_0))
    else $error("first enable changed without a write");

  // same for the second window
  mask_keep_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(write_strobe && sel_1 && offset == uic_pkg::UIC_OFS_MASK)
    |=> $stable(mask_1))
    else $error("second enable changed without a write");

  // writes to identification offsets have nowhere to land
  id_write_ignored_a: assert property (@(posedge clock) disable iff (!arst_n)
    (write_strobe && id_hit)
    |=> ($stable(mask_0) && $stable(mask_1)))
    else $error("identification write altered state");

  // read data stands for one cycle only, zero otherwise
  read_idle_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    !read_strobe
    |=> read_data == uic_pkg::UIC_ZERO)
    else $error("read data not zero while idle");

  // the clear register has no storage, so it reads zero
  clear_reads_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && (sel_0 || sel_1) && offset == uic_pkg::UIC_OFS_CLEAR)
    |=> read_data == uic_pkg::UIC_ZERO)
    else $error("clear register read not zero");

  // addresses outside both windows must not answer
  outside_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && !sel_0 && !sel_1)
    |=> read_data == uic_pkg::UIC_ZERO)
    else $error("read outside windows not zero");

  // raw status read returns the flags as they stood at the strobe
  raw_read_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_0 && offset == uic_pkg::UIC_OFS_RAW)
    |=> read_data == {24'h000000, $past(raw_0), 4'h0})
    else $error("raw status read wrong");

  // second window raw status
  raw_read_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_1 && offset == uic_pkg::UIC_OFS_RAW)
    |=> read_data == {24'h000000, $past(raw_1), 4'h0})
    else $error("second raw status read wrong");

  // masked status is raw gated by the enables
  mis_read_0_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_0 && offset == uic_pkg::UIC_OFS_MIS)
    |=> read_data == {24'h000000, $past(raw_0 & mask_0), 4'h0})
    else $error("masked status read wrong");

  // identification bytes answer in the second window too
  id_read_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_1 && offset == uic_pkg::UIC_OFS_ID0)
    |=> read_data == {24'h000000, uic_pkg::UIC_ID_BYTE0})
    else $error("second identification byte wrong");

  // byte 2 lands in bits 7:0, upper bits zero
  id_read_2_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_0 && offset == uic_pkg::UIC_OFS_ID2)
    |=> read_data == {24'h000000, uic_pkg::UIC_ID_BYTE2})
    else $error("identification byte 2 wrong");

  // byte 4 lands in bits 7:0, upper bits zero
  id_read_4_a: assert property (@(posedge clock) disable iff (!arst_n)
    (read_strobe && sel_0 && offset == uic_pkg::UIC_OFS_ID4)
    |=> read_data == {24'h000000, uic_pkg::UIC_ID_BYTE4})
    else $error("identification byte 4 wrong");

  // a full clear in the second window drops its line
  masked_drop_1_a: assert property (@(posedge clock) disable iff (!arst_n)
    (is_clear && sel_1 && (write_data[7:4] == 4'hF) && events_1 == 4'h0)
    |=> !irq_1)
    else $error("second interrupt stayed after full clear");
endmodule
`default_nettype wire

// File: tb/test_uart_int_clear_and_id_regs.sv
// test_uart_int_clear_and_id_regs: self-checking bench for the clear and ident bank.
// assumes read data one cycle after the strobe, no wait states, one clock.
`timescale 1ns/1ps
`default_nettype none
module test_uart_int_clear_and_id_regs;
  logic clock = 1'b0; // 125 MHz
  logic arst_n = 1'b0; // held low at start
  logic [31:0] address = 32'h0000_0000;
  logic [31:0] write_data = 32'h0000_0000;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [31:0] read_data;
  logic [3:0] events_0 = 4'h0; // bit0 rx .. bit3 framing
  logic [3:0] events_1 = 4'h0;
  logic irq_0;
  logic irq_1;
  int err_total = 0; // mismatches
  int checked = 0; // comparisons made
  // ident offsets and bytes, in table order
  logic [11:0] id_ofs [7] = '{uic_pkg::UIC_OFS_ID4, uic_pkg::UIC_OFS_ID5, uic_pkg::UIC_OFS_ID6,
    uic_pkg::UIC_OFS_ID7, uic_pkg::UIC_OFS_ID0, uic_pkg::UIC_OFS_ID1, uic_pkg::UIC_OFS_ID2};
  logic [7:0] id_val [7] = '{uic_pkg::UIC_ID_BYTE4, uic_pkg::UIC_ID_BYTE5, uic_pkg::UIC_ID_BYTE6,
    uic_pkg::UIC_ID_BYTE7, uic_pkg::UIC_ID_BYTE0, uic_pkg::UIC_ID_BYTE1, uic_pkg::UIC_ID_BYTE2};

  uic_regs dut (.clock(clock), .arst_n(arst_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .events_0(events_0), .events_1(events_1), .irq_0(irq_0), .irq_1(irq_1));

  // free-running clock
  always #4 clock = ~clock;

  // full address of an offset in one of the two windows
  function automatic logic [31:0] adr(input logic inst, input logic [11:0] ofs);
    return (inst ? uic_pkg::UIC_BASE_1 : uic_pkg::UIC_BASE_0) | {20'h0_0000, ofs};
  endfunction

  // read data comparison
  task automatic chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error read %h expected %h seen %h", a, exp, got);
    end
  endtask

  // interrupt lines comparison, {irq_1, irq_0}
  task automatic chk_irq(input logic [1:0] exp);
    #1;
    checked++;
    if ({irq_1, irq_0} !== exp) begin
      err_total++;
      $display("Error irq expected %b seen %b", exp, {irq_1, irq_0});
    end
  endtask

  // one-cycle write; a cycle passes before the strobe can rise again
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  // one-cycle read, data sampled in the single cycle it stands
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    chk(a, exp, read_data);
  endtask

  // one-cycle event pulses on both instances
  task automatic ev(input logic [3:0] e0, input logic [3:0] e1);
    @(posedge clock);
    events_0 <= e0;
    events_1 <= e1;
    @(posedge clock);
    events_0 <= 4'h0;
    events_1 <= 4'h0;
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("Checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #40000;
    err_total++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    // ident bytes survive a write and appear in both windows
    for (int i = 0; i < 7; i++) begin
      wr(adr(0, id_ofs[i]), 32'hFFFF_FFFF);
      rd(adr(0, id_ofs[i]), {24'h00_0000, id_val[i]});
      rd(adr(1, id_ofs[i]), {24'h00_0000, id_val[i]});
    end
    rd(adr(0, uic_pkg::UIC_OFS_CLEAR), 32'h0000_0000);
    rd(adr(0, uic_pkg::UIC_OFS_RAW), 32'h0000_0000);
    // all four events on instance 0 only, still masked
    ev(4'hF, 4'h0);
    rd(adr(0, uic_pkg::UIC_OFS_RAW), 32'h0000_00F0);
    rd(adr(1, uic_pkg::UIC_OFS_RAW), 32'h0000_0000);
    chk_irq(2'b00);
    wr(adr(0, uic_pkg::UIC_OFS_MASK), 32'h0000_00F0);
    chk_irq(2'b01);
    rd(adr(0, uic_pkg::UIC_OFS_MIS), 32'h0000_00F0);
    // an all-zero write to the clear register clears nothing
    wr(adr(0, uic_pkg::UIC_OFS_CLEAR), 32'h0000_0000);
    rd(adr(0, uic_pkg::UIC_OFS_RAW), 32'h0000_00F0);
    // clear one bit at a time, raw and masked both drop
    for (int b = 4; b < 8; b++) begin
      wr(adr(0, uic_pkg::UIC_OFS_CLEAR), 32'h0000_0001 << b);
      rd(adr(0, uic_pkg::UIC_OFS_RAW), (32'h0000_00FF << (b + 1)) & 32'h0000_00F0);
      rd(adr(0, uic_pkg::UIC_OFS_MIS), (32'h0000_00FF << (b + 1)) & 32'h0000_00F0);
    end
    chk_irq(2'b00);
    // instance 1 framing error, cleared only through its own window
    wr(adr(1, uic_pkg::UIC_OFS_MASK), 32'h0000_00F0);
    ev(4'h0, 4'h8);
    chk_irq(2'b10);
    wr(adr(0, uic_pkg::UIC_OFS_CLEAR), 32'h0000_0080);
    rd(adr(1, uic_pkg::UIC_OFS_RAW), 32'h0000_0080);
    wr(adr(1, uic_pkg::UIC_OFS_CLEAR), 32'h0000_0080);
    rd(adr(1, uic_pkg::UIC_OFS_RAW), 32'h0000_0000);
    // receive event in the very cycle its clear is written: event wins
    @(posedge clock);
    events_0 <= 4'h1;
    address <= adr(0, uic_pkg::UIC_OFS_CLEAR);
    write_data <= 32'h0000_0010;
    write_strobe <= 1'b1;
    @(posedge clock);
    events_0 <= 4'h0;
    write_strobe <= 1'b0;
    rd(adr(0, uic_pkg::UIC_OFS_RAW), 32'h0000_0010);
    chk_irq(2'b01);
    // masking drops the line but keeps the raw flag
    wr(adr(0, uic_pkg::UIC_OFS_MASK), 32'h0000_0000);
    chk_irq(2'b00);
    rd(adr(0, uic_pkg::UIC_OFS_RAW), 32'h0000_0010);
    // unmapped offset and an address outside both windows read zero
    rd(adr(0, 12'h100), 32'h0000_0000);
    rd(32'h4000_EFE0, 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
